// >>> hdl/wds_pkg.sv
/*
 Constants, register map and state types for the watchdog with sleep entry.
 Assumes a single 50 MHz system clock and an 8-bit register port.
*/
`default_nettype none

package wds_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register port
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 8;
   localparam logic [7:0]  ADDR_WDCTL     = 8'h00;
   localparam logic [7:0]  ADDR_OPTION    = 8'h01;
   localparam logic [7:0]  ADDR_STATUS    = 8'h02;
   localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h03;
   localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_EN    = 8'h05;

   ////////////////////////////////////////////////////////////////////////
   // Watchdog control fields and reset values
   localparam int          CTL_EN_BIT     = 0;
   localparam int          CTL_PS_LSB     = 1;
   localparam int          CTL_PS_MSB     = 4;
   localparam logic [3:0]  PS_RESET       = 4'h4;
   localparam logic [3:0]  PS_LAST_LEGAL  = 4'hB;
   localparam logic        SW_EN_RESET    = 1'b0;
   localparam logic [7:0]  OPTION_RESET   = 8'hFF;

   // Status layout
   localparam int          STAT_PD_BIT    = 0;
   localparam int          STAT_TO_BIT    = 1;
   localparam int          STAT_SLP_BIT   = 2;

   // Interrupt events
   localparam int          IRQ_N          = 3;
   localparam int          IRQ_RESET_BIT  = 0;
   localparam int          IRQ_WAKE_BIT   = 1;
   localparam int          IRQ_SLEEP_BIT  = 2;

   ////////////////////////////////////////////////////////////////////////
   // Time base
   localparam int          LF_OSC_KHZ     = 31;
   localparam int          NOMINAL_MS     = 17;
   localparam int          CNT_W          = 17;
   localparam logic [16:0] PRESCALE_MIN   = 17'h0_0020;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0]
   {
      WDS_RUN   = 2'h0,
      WDS_SLEEP = 2'h1,
      WDS_OST   = 2'h3
   } wds_state_type;

   typedef enum logic [2:0]
   {
      WDS_CLK_LOW_POWER_XTAL = 3'h0,
      WDS_CLK_STANDARD_XTAL  = 3'h1,
      WDS_CLK_HIGH_SPEED     = 3'h2,
      WDS_CLK_EXTERNAL_RC    = 3'h3,
      WDS_CLK_INTERNAL_OSC   = 3'h4,
      WDS_CLK_EXTERNAL_INPUT = 3'h5,
      WDS_CLK_TIMER1_OSC     = 3'h6
   } wds_clk_mode_type;

endpackage

`default_nettype wire

// >>> hdl/wds_counter.sv
/*
 Prescaled watchdog counter, synchronous to mclk_in, advanced by low-frequency ticks.
 Assumes tick_in is a one-cycle pulse on the system clock.
*/
`default_nettype none

module wds_counter
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   // Control
   input  wire logic        clear_in,
   input  wire logic        tick_in,
   input  wire logic [3:0]  period_in,
   // Result
   output logic      [16:0] count_out,
   output logic             expired_out
);

   typedef struct packed
   {
      logic [16:0] cnt;
      logic        expired;
   } wds_cnt_state_type;

   wds_cnt_state_type q;
   wds_cnt_state_type d;
   logic [3:0]        ps;
   logic [16:0]       last;

   always_comb
   begin
      // Reserved codes run at the longest rate
      ps = (period_in > wds_pkg::PS_LAST_LEGAL) ?
           wds_pkg::PS_LAST_LEGAL : period_in;
      last = (wds_pkg::PRESCALE_MIN << ps) - 17'h0_0001;
      d = q;
      d.expired = 1'b0;
      if (clear_in)
      begin
         d.cnt = 17'h0_0000;
      end
      else if (tick_in)
      begin
         if (q.cnt == last)
         begin
            d.cnt     = 17'h0_0000;
            d.expired = 1'b1;
         end
         else
         begin
            d.cnt = q.cnt + 17'h0_0001;
         end
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         q <= '0;
      end
      else if (ce_in)
      begin
         q <= d;
      end
   end

   assign count_out   = q.cnt;
   assign expired_out = q.expired;

endmodule

`default_nettype wire

// >>> hdl/wds_top.sv
/*
 Watchdog timer with sleep entry, wake and I/O hold, plus register port.
 Assumes core strobes are one-cycle pulses on mclk_in; the low-frequency
 oscillator and master clear pin are asynchronous and synchronised here.
*/
// Decided for this implementation: the plain strobed port and the address map.
//
// Overview of operation
// - Counter cleared: disabled, clear, fail, sleep exit
// - Crystal modes hold counter until startup done
// - Configuration enable forces watchdog on
// - Time base is 31 kHz oscillator
// - Power-down only through sleep instruction
// - Sleep entry clears counter, keeps counting
// - Sleep entry clears power-down, sets time-out
// - Main oscillator driver off while asleep
// - I/O drive state frozen during sleep
// - Watchdog reset never drives master clear
// - Watchdog expiry clears time-out flag
`default_nettype none

module wds_top
(
   // Clock, reset, enable
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   // Core events
   input  wire logic        config_watchdog_enable_in,
   input  wire logic        clear_watchdog_instruction_in,
   input  wire logic        sleep_instruction_in,
   input  wire logic        osc_fail_in,
   input  wire logic        wake_request_in,
   input  wire logic [2:0]  clk_mode_in,
   input  wire logic        oscillator_startup_timer_done_in,
   // Pins
   input  wire logic        low_freq_internal_osc_in,
   input  wire logic        master_clear_pin_n_in,
   // I/O drive from the port logic
   input  wire logic [7:0]  io_val_in,
   input  wire logic [7:0]  io_oe_in,
   // Outputs
   output logic      [7:0]  io_val_out,
   output logic      [7:0]  io_oe_out,
   output logic             osc_driver_en_out,
   output logic             sleeping_out,
   output logic             system_reset_out,
   output logic             irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed
   {
      wds_pkg::wds_state_type st;
      logic [3:0]             period;
      logic                   sw_en;
      logic [7:0]             option;
      logic                   pd;
      logic                   to;
      logic [2:0]             irq_st;
      logic [2:0]             irq_en;
      logic [7:0]             rdata;
      logic [7:0]             io_val;
      logic [7:0]             io_oe;
      logic                   rst_pulse;
      logic [2:0]             lf_sync;
      logic [1:0]             master_clear_pin_sync;
   } wds_top_state_type;

   wds_top_state_type q;
   wds_top_state_type d;

   logic        lf_tick;
   logic        master_clear_pin_low;
   logic        wdt_en;
   logic        crystal;
   logic        sleep_go;
   logic        timeout;
   logic        wake;
   logic        cnt_clear;
   logic        expired;
   logic [16:0] cnt;

   ////////////////////////////////////////////////////////////////////////
   // Counter

   wds_counter u_counter
   (
      .mclk_in     (mclk_in),
      .rst_in      (rst_in),
      .ce_in       (ce_in),
      .clear_in    (cnt_clear),
      .tick_in     (lf_tick),
      .period_in   (q.period),
      .count_out   (cnt),
      .expired_out (expired)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      d = q;

      // Pin synchronisers
      d.lf_sync   = {q.lf_sync[1:0], low_freq_internal_osc_in};
      d.master_clear_pin_sync = {q.master_clear_pin_sync[0], master_clear_pin_n_in};
      lf_tick  = q.lf_sync[1] & ~q.lf_sync[2];
      // master clear low means external reset
      master_clear_pin_low = ~q.master_clear_pin_sync[1];

      wdt_en  = config_watchdog_enable_in | q.sw_en;
      crystal = (clk_mode_in == wds_pkg::WDS_CLK_LOW_POWER_XTAL) |
                (clk_mode_in == wds_pkg::WDS_CLK_STANDARD_XTAL) |
                (clk_mode_in == wds_pkg::WDS_CLK_HIGH_SPEED);
      timeout = expired & wdt_en & (q.st != wds_pkg::WDS_OST);
      // only the sleep instruction enters power-down
      sleep_go = (q.st == wds_pkg::WDS_RUN) & sleep_instruction_in &
                 ~master_clear_pin_low & ~timeout;
      wake     = (q.st == wds_pkg::WDS_SLEEP) &
                 (wake_request_in | timeout);

      // cleared on sleep entry, then counts on
      cnt_clear = ~wdt_en | clear_watchdog_instruction_in | osc_fail_in |
                  sleep_go | wake | (q.st == wds_pkg::WDS_OST) | master_clear_pin_low;

      // Read data stand for one cycle only
      d.rdata     = 8'h00;
      d.rst_pulse = 1'b0;

      if (rd_in)
      begin
         case (addr_in)
            // upper control bits read as zero
            wds_pkg::ADDR_WDCTL:
               d.rdata = {3'h0, q.period, q.sw_en};
            wds_pkg::ADDR_OPTION:
               d.rdata = q.option;
            wds_pkg::ADDR_STATUS:
               d.rdata = {5'h00, q.st == wds_pkg::WDS_SLEEP, q.to, q.pd};
            wds_pkg::ADDR_IRQ_STAT:
               d.rdata = {5'h00, q.irq_st};
            wds_pkg::ADDR_IRQ_EN:
               d.rdata = {5'h00, q.irq_en};
            default:
               d.rdata = 8'h00;
         endcase
      end

      if (wr_in)
      begin
         case (addr_in)
            wds_pkg::ADDR_WDCTL:
            begin
               d.period =
                  wdata_in[wds_pkg::CTL_PS_MSB:wds_pkg::CTL_PS_LSB];
               d.sw_en  = wdata_in[wds_pkg::CTL_EN_BIT];
            end
            wds_pkg::ADDR_OPTION:
               d.option = wdata_in;
            wds_pkg::ADDR_IRQ_CLR:
               d.irq_st = q.irq_st & ~wdata_in[2:0];
            wds_pkg::ADDR_IRQ_EN:
               d.irq_en = wdata_in[2:0];
            default:
               d.irq_en = d.irq_en;
         endcase
      end

      // port drive follows core until asleep
      if (q.st != wds_pkg::WDS_SLEEP)
      begin
         d.io_val = io_val_in;
         d.io_oe  = io_oe_in;
      end

      if (clear_watchdog_instruction_in &&
          (q.st == wds_pkg::WDS_RUN))
      begin
         d.pd = 1'b1;
         d.to = 1'b1;
      end

      case (q.st)
         wds_pkg::WDS_RUN:
         begin
            if (timeout)
            begin
               d.rst_pulse = 1'b1;
               d.to        = 1'b0;
               d.irq_st[wds_pkg::IRQ_RESET_BIT] = 1'b1;
            end
            else if (sleep_go)
            begin
               d.st = wds_pkg::WDS_SLEEP;
               d.pd = 1'b0;
               d.to = 1'b1;
               d.irq_st[wds_pkg::IRQ_SLEEP_BIT] = 1'b1;
            end
         end
         wds_pkg::WDS_SLEEP:
         begin
            if (wake)
            begin
               // crystal modes wait for startup count
               d.st = crystal ? wds_pkg::WDS_OST : wds_pkg::WDS_RUN;
               if (timeout)
               begin
                  // expiry in sleep wakes, no reset
                  d.to = 1'b0;
                  d.irq_st[wds_pkg::IRQ_WAKE_BIT] = 1'b1;
               end
            end
         end
         wds_pkg::WDS_OST:
         begin
            if (oscillator_startup_timer_done_in)
            begin
               d.st = wds_pkg::WDS_RUN;
            end
         end
         default:
            d.st = wds_pkg::WDS_RUN;
      endcase

      // Any reset restores the control register
      if (master_clear_pin_low || d.rst_pulse)
      begin
         d.period = wds_pkg::PS_RESET;
         d.sw_en  = wds_pkg::SW_EN_RESET;
      end
      if (master_clear_pin_low)
      begin
         d.st = wds_pkg::WDS_RUN;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         q           <= '0;
         q.st        <= wds_pkg::WDS_RUN;
         q.period    <= wds_pkg::PS_RESET;
         q.sw_en     <= wds_pkg::SW_EN_RESET;
         q.option    <= wds_pkg::OPTION_RESET;
         q.pd        <= 1'b1;
         q.to        <= 1'b1;
         q.master_clear_pin_sync <= 2'h3;
      end
      else if (ce_in)
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rdata_out         = q.rdata;
   assign io_val_out        = q.io_val;
   assign io_oe_out         = q.io_oe;
   assign osc_driver_en_out = (q.st != wds_pkg::WDS_SLEEP);
   assign sleeping_out      = (q.st == wds_pkg::WDS_SLEEP);
   // watchdog pulse or synchronised master clear, pin is input
   assign system_reset_out  = q.rst_pulse | ~q.master_clear_pin_sync[1];
   assign irq_out           = |(q.irq_st & q.irq_en);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking wds_cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   sleep_entry_flags_a: assert property (
      ce_in && sleep_go |=> !q.pd && q.to && sleeping_out)
      else $error("sleep entry flags wrong");

   osc_driver_off_a: assert property (
      ce_in && sleep_go |=> !osc_driver_en_out [*1] ##0 sleeping_out)
      else $error("oscillator driver not off in sleep");

   io_hold_sleep_a: assert property (
      sleeping_out && $past(sleeping_out) |->
      $stable(io_val_out) && $stable(io_oe_out))
      else $error("io drive changed during sleep");

   sleep_cause_only_a: assert property (
      !sleeping_out ##1 sleeping_out |->
      $past(sleep_instruction_in, 1))
      else $error("sleep without sleep instruction");

   startup_hold_cnt_a: assert property (
      (q.st == wds_pkg::WDS_OST) ##1 (q.st == wds_pkg::WDS_OST) |->
      cnt == 17'h0_0000)
      else $error("counter ran during oscillator startup");

   run_expiry_reset_a: assert property (
      ce_in && !sleeping_out && timeout |=>
      system_reset_out && !q.to && !sleeping_out)
      else $error("running expiry did not reset");

   sleep_expiry_wake_a: assert property (
      ce_in && sleeping_out && timeout && !master_clear_pin_low |=>
      !sleeping_out && !q.to && !q.rst_pulse)
      else $error("sleep expiry did not wake");

   disabled_cnt_zero_a: assert property (
      ce_in && !wdt_en |=> cnt == 17'h0_0000)
      else $error("counter not cleared while disabled");

   sleep_cnt_clear_a: assert property (
      ce_in && sleep_go |=> cnt == 17'h0_0000 && sleeping_out)
      else $error("counter not cleared on sleep entry");

   ctl_readback_a: assert property (
      ce_in && rd_in && addr_in == wds_pkg::ADDR_WDCTL |=>
      rdata_out[7:5] == 3'h0 && rdata_out[4:1] == $past(q.period))
      else $error("control readback wrong");

endmodule

`default_nettype wire

// >>> verif/wds_testbench.sv
/*
 Self-checking bench for the watchdog with sleep entry (wds_top).
 Assumes wds_pkg and wds_top are compiled first; one 50 MHz clock.
*/
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic       mclk_in, rst_in, ce_in, wr_in, rd_in, osc_fail_in;
   logic       config_watchdog_enable_in, clear_watchdog_instruction_in;
   logic       sleep_instruction_in, wake_request_in;
   logic       oscillator_startup_timer_done_in, master_clear_pin_n_in;
   logic       low_freq_internal_osc_in;
   logic [2:0] clk_mode_in;
   logic [7:0] addr_in, wdata_in, io_val_in, io_oe_in;
   logic [7:0] rdata_out, io_val_out, io_oe_out;
   logic       osc_driver_en_out, sleeping_out, system_reset_out, irq_out;
   logic [1:0] lf_q = 2'h0;
   int         num_errors, checked;

   wds_top dut
   (
      .mclk_in, .rst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .config_watchdog_enable_in,
      .clear_watchdog_instruction_in, .sleep_instruction_in,
      .osc_fail_in, .wake_request_in, .clk_mode_in,
      .oscillator_startup_timer_done_in, .low_freq_internal_osc_in,
      .master_clear_pin_n_in, .io_val_in, .io_oe_in, .io_val_out,
      .io_oe_out, .osc_driver_en_out, .sleeping_out, .system_reset_out,
      .irq_out
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock and a fast low-frequency oscillator, one tick per 4 clocks
   initial
   begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end

   always @(posedge mclk_in)
      lf_q <= lf_q + 2'h1;
   assign low_freq_internal_osc_in = lf_q[1];

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic near(string name, int n, int exp);
      check(name, {7'h00, n >= exp - 4 && n <= exp + 14}, 8'h01);
   endtask

   task automatic step(int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      #1;
   endtask

   task automatic rdck(string name, logic [7:0] a, logic [7:0] exp);
      @(posedge mclk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1;
      check(name, rdata_out, exp);
   endtask

   // Pulse 0 sleep, 1 wake, 2 clear, 3 startup done
   task automatic pulse(int k);
      for (int v = 1; v >= 0; v--)
      begin
         @(posedge mclk_in);
         case (k)
            0: sleep_instruction_in <= v[0];
            1: wake_request_in <= v[0];
            2: clear_watchdog_instruction_in <= v[0];
            default: oscillator_startup_timer_done_in <= v[0];
         endcase
      end
      #1;
   endtask

   // Cycles until reset rises (k 0) or sleep ends (k 1)
   task automatic wait_for(int k, output int n);
      n = 0;
      while (n < 3000 && (k == 0 ? system_reset_out !== 1'b1
                                 : sleeping_out !== 1'b0))
      begin
         step(1);
         n++;
      end
   endtask

   task automatic no_reset(string name, int n, bit clr);
      int hits;
      hits = 0;
      for (int i = 0; i < n; i++)
      begin
         @(posedge mclk_in);
         clear_watchdog_instruction_in <= clr && (i % 40 == 0);
         #1;
         if (system_reset_out !== 1'b0)
            hits++;
      end
      check(name, hits[7:0], 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      check("sleeping", {7'h00, sleeping_out}, 8'h00);
      rdck("ctl reset", wds_pkg::ADDR_WDCTL, 8'h08);
      rdck("option reset", wds_pkg::ADDR_OPTION, 8'hFF);
      rdck("status reset", wds_pkg::ADDR_STATUS, 8'h03);
      rdck("unmapped", 8'h3C, 8'h00);
      wr(wds_pkg::ADDR_WDCTL, 8'hFF);
      rdck("ctl upper", wds_pkg::ADDR_WDCTL, 8'h1F);
      wr(wds_pkg::ADDR_WDCTL, 8'h00);
      rdck("ctl off", wds_pkg::ADDR_WDCTL, 8'h00);
      wr(wds_pkg::ADDR_OPTION, 8'h5A);
      rdck("option rw", wds_pkg::ADDR_OPTION, 8'h5A);
      // Strobes are lost while the clock enable is low
      @(posedge mclk_in);
      ce_in <= 1'b0;
      wr(wds_pkg::ADDR_OPTION, 8'hC3);
      @(posedge mclk_in);
      ce_in <= 1'b1;
      rdck("frozen", wds_pkg::ADDR_OPTION, 8'h5A);
   endtask

   task automatic t_period();
      int n;
      for (int p = 0; p < 3; p++)
      begin
         wr(wds_pkg::ADDR_WDCTL, {3'h0, p[3:0], 1'b1});
         wait_for(0, n);
         near("timeout span", n, 128 << p);
         step(1);
         check("reset width", {7'h00, system_reset_out}, 8'h00);
         rdck("ctl restored", wds_pkg::ADDR_WDCTL, 8'h08);
         rdck("status to", wds_pkg::ADDR_STATUS, 8'h01);
         rdck("irq reset", wds_pkg::ADDR_IRQ_STAT, 8'h01);
         wr(wds_pkg::ADDR_IRQ_CLR, 8'h07);
      end
   endtask

   task automatic t_enables();
      int n;
      @(posedge mclk_in);
      config_watchdog_enable_in <= 1'b1;
      #1;
      wait_for(0, n);
      near("forced on", n, 2048);
      @(posedge mclk_in);
      config_watchdog_enable_in <= 1'b0;
      // Shortest period, so a missing clear would reset
      wr(wds_pkg::ADDR_WDCTL, 8'h00);
      no_reset("disabled", 300, 1'b0);
      wr(wds_pkg::ADDR_WDCTL, 8'h01);
      no_reset("clear instr", 400, 1'b1);
      @(posedge mclk_in);
      osc_fail_in <= 1'b1;
      no_reset("osc fail", 300, 1'b0);
      @(posedge mclk_in);
      osc_fail_in <= 1'b0;
      wr(wds_pkg::ADDR_WDCTL, 8'h00);
      wr(wds_pkg::ADDR_IRQ_CLR, 8'h07);
   endtask

   task automatic t_sleep_io();
      @(posedge mclk_in);
      io_val_in <= 8'hA5;
      io_oe_in  <= 8'h0F;
      step(2);
      pulse(0);
      check("asleep", {7'h00, sleeping_out}, 8'h01);
      check("osc off", {7'h00, osc_driver_en_out}, 8'h00);
      @(posedge mclk_in);
      io_val_in <= 8'h5A;
      io_oe_in  <= 8'hF0;
      step(3);
      check("io val held", io_val_out, 8'hA5);
      check("io oe held", io_oe_out, 8'h0F);
      // Master clear stays high all through sleep
      pulse(1);
      check("awake", {7'h00, sleeping_out}, 8'h00);
      check("osc on", {7'h00, osc_driver_en_out}, 8'h01);
      step(2);
      check("io val live", io_val_out, 8'h5A);
      check("io oe live", io_oe_out, 8'hF0);
      rdck("status sleep", wds_pkg::ADDR_STATUS, 8'h02);
      rdck("irq sleep", wds_pkg::ADDR_IRQ_STAT, 8'h04);
   endtask

   task automatic t_sleep_wake();
      int n;
      wr(wds_pkg::ADDR_WDCTL, 8'h01);
      step(100);
      pulse(0);
      wait_for(1, n);
      near("sleep timeout", n, 128);
      rdck("ctl kept", wds_pkg::ADDR_WDCTL, 8'h01);
      wr(wds_pkg::ADDR_WDCTL, 8'h00);
      rdck("status wake", wds_pkg::ADDR_STATUS, 8'h00);
      rdck("irq wake", wds_pkg::ADDR_IRQ_STAT, 8'h06);
      wr(wds_pkg::ADDR_IRQ_EN, 8'h02);
      step(1);
      check("irq on", {7'h00, irq_out}, 8'h01);
      wr(wds_pkg::ADDR_IRQ_CLR, 8'h02);
      step(1);
      check("irq masked", {7'h00, irq_out}, 8'h00);
      rdck("irq left", wds_pkg::ADDR_IRQ_STAT, 8'h04);
      wr(wds_pkg::ADDR_IRQ_EN, 8'h04);
      step(1);
      check("irq bit2", {7'h00, irq_out}, 8'h01);
      wr(wds_pkg::ADDR_IRQ_EN, 8'h00);
   endtask

   task automatic t_crystal();
      int n;
      // Every clock mode; crystal modes 0..2 pass the startup hold
      for (int m = 0; m < 7; m++)
      begin
         @(posedge mclk_in);
         clk_mode_in <= m[2:0];
         wr(wds_pkg::ADDR_WDCTL, 8'h01);
         pulse(0);
         // Counter advances in sleep, so wake must clear it
         step(60);
         pulse(1);
         check("ost osc on", {7'h00, osc_driver_en_out}, 8'h01);
         if (m < 3)
         begin
            no_reset("ost hold", 300, 1'b0);
            pulse(3);
         end
         wait_for(0, n);
         near("after wake", n, 128);
      end
      @(posedge mclk_in);
      clk_mode_in <= 3'h4;
      master_clear_pin_n_in <= 1'b0;
      step(4);
      check("pin reset", {7'h00, system_reset_out}, 8'h01);
      @(posedge mclk_in);
      master_clear_pin_n_in <= 1'b1;
      step(4);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial
   begin
      {wr_in, rd_in, osc_fail_in, config_watchdog_enable_in} = 4'h0;
      {sleep_instruction_in, wake_request_in} = 2'h0;
      clear_watchdog_instruction_in = 1'b0;
      oscillator_startup_timer_done_in = 1'b0;
      {addr_in, wdata_in, io_val_in, io_oe_in} = 32'h0000_0000;
      {rst_in, ce_in, master_clear_pin_n_in} = 3'h7;
      clk_mode_in = 3'h4;
      repeat (16) @(posedge mclk_in);
      rst_in <= 1'b0;
      step(3);
      t_regs();
      t_period();
      t_enables();
      t_sleep_io();
      t_sleep_wake();
      t_crystal();
      tally_and_finish();
   end

   initial
   begin
      repeat (14000) @(posedge mclk_in);
      num_errors++;
      tally_and_finish();
   end
endmodule

`default_nettype wire
